// ---- design/ssp_pkg.sv ----
// Package of widths, reset values and timing for the burst SRAM port control
package ssp_pkg;
  localparam int          SSP_ADDR_W     = 19;
  localparam int          SSP_LANES      = 4;
  localparam int          SSP_LANE_W     = 8;
  localparam int          SSP_DATA_W     = SSP_LANES * SSP_LANE_W;
  localparam int          SSP_BURST_LSB  = 0;
  localparam int          SSP_BURST_W    = 2;
  localparam logic [3:0]  SSP_ALL_LANES  = 4'hf;
  localparam logic [3:0]  SSP_NO_LANES   = 4'h0;
  localparam logic [1:0]  SSP_STEP_RST   = 2'h0;
  // Edges of a stable synchronised sleep level before entering or leaving
  localparam int          SSP_SLEEP_EDGES = 2;
  localparam logic [1:0]  SSP_SLEEP_CNT_RST = 2'h0;
endpackage : ssp_pkg

// ---- design/ssp_burst_seq.sv ----
// Two-bit burst address sequence, linear or interleaved
`timescale 1ns/100ps
`default_nettype none
module ssp_burst_seq
  import ssp_pkg::*;
(
  // Burst position
  input  wire logic [1:0] start_bits,
  input  wire logic [1:0] step,
  // Order select, high for interleaved
  input  wire logic       interleave,
  // Low address bits to the core
  output logic      [1:0] addr_bits
);
  always_comb begin
    if (interleave) begin
      addr_bits = start_bits ^ step;
    end else begin
      addr_bits = 2'(start_bits + step);
    end
  end
endmodule : ssp_burst_seq
`default_nettype wire

// ---- design/ssp_port_ctrl.sv ----
// Pin-side control of a flow-through burst SRAM with common data bus
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Synchronous pins are taken only at the rising clock edge.
// - Burst counter steps once per edge with advance low during a burst.
// - Selected only when select a low, select b high, select c low.
// - Selects are looked at only when a new address loads.
// - Processor strobe ignored when select a is high.
// - A recognised strobe loads the address and the low two bits.
// - Both strobes low with select a low: only the processor strobe counts.
// - Output enable low drives data pins; high floats them.
// - Output enable masked in the first read clock after deselect.
// - Write data is captured from the data pins at the clock edge.
// - Read data is that of the address taken at the previous edge.
// - Pins float on write data phase, first clock after deselect, deselect.
// - Strap low gives linear order, high or open gives interleaved.
// - Sleep input high enters data-retaining sleep; low is normal.
// - Global write low writes all four lanes, overriding lane controls.
// - Interleaved order XORs the start; linear adds, wrapping mod four.
// - Sleep takes four clocks to enter or leave; master stays idle.
// - Besides global write, a lane is written only with lane write enable and its select low.
module ssp_port_ctrl
  import ssp_pkg::*;
#(
  parameter int ADDR_W = SSP_ADDR_W
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // Address and strobes
  input  wire logic [ADDR_W-1:0]     addr,
  input  wire logic                  cpu_addr_strobe_n,
  input  wire logic                  ctrl_addr_strobe_n,
  input  wire logic                  burst_advance_n,
  // Chip selects
  input  wire logic                  select_a_n,
  input  wire logic                  select_b_hi,
  input  wire logic                  select_c_n,
  // Write controls
  input  wire logic                  all_lanes_write_n,
  input  wire logic                  lane_write_enable_n,
  input  wire logic [SSP_LANES-1:0]  lane_select_n,
  // Asynchronous pins and strap
  input  wire logic                  out_enable_n,
  input  wire logic                  sleep_request,
  input  wire logic                  burst_order_strap,
  // Data pins
  input  wire logic [SSP_DATA_W-1:0] dq_in,
  output logic      [SSP_DATA_W-1:0] dq_out,
  output logic                       dq_oe,
  // Memory core side
  output logic      [ADDR_W-1:0]     core_addr,
  output logic      [SSP_LANES-1:0]  core_lane_we,
  output logic      [SSP_DATA_W-1:0] core_wdata,
  input  wire logic [SSP_DATA_W-1:0] core_rdata,
  // Status
  output logic                       sleep_active
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Whole port state, registered as one word
  typedef struct packed {
    logic [ADDR_W-1:0]     addr;
    logic [1:0]            step;
    logic                  active;
    logic                  read_phase;
    logic                  oe_mask;
    logic [SSP_LANES-1:0]  lane_we;
    logic [SSP_DATA_W-1:0] wdata;
    logic [1:0]            sleep_sync;
    logic [1:0]            strap_sync;
    logic [1:0]            sleep_cnt;
    logic                  asleep;
  } ssp_state_t;

  ssp_state_t st_ff;
  ssp_state_t nxt_st;

  logic       cpu_ok;
  logic       ctrl_ok;
  logic       load;
  logic       selected;
  logic       write_now;
  logic [3:0] lanes;
  logic [1:0] nxt_step;
  logic [1:0] burst_bits;

  ssp_burst_seq u_seq (
    .start_bits (st_ff.addr[SSP_BURST_LSB +: SSP_BURST_W]),
    .step       (st_ff.step),
    .interleave (st_ff.strap_sync[1]),
    .addr_bits  (burst_bits)
  );

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // All three selects at their active levels
  function automatic logic chip_selected(input logic sel_a_n,
                                         input logic sel_b_hi,
                                         input logic sel_c_n);
    return !sel_a_n && sel_b_hi && !sel_c_n;
  endfunction : chip_selected

  // Lanes a write request touches; global write wins
  function automatic logic [SSP_LANES-1:0] lane_mask(
    input logic                 global_n,
    input logic                 enable_n,
    input logic [SSP_LANES-1:0] select_n
  );
    logic [SSP_LANES-1:0] mask;
    if (!global_n) begin
      mask = SSP_ALL_LANES;
    end else if (!enable_n) begin
      mask = ~select_n;
    end else begin
      mask = SSP_NO_LANES;
    end
    return mask;
  endfunction : lane_mask

  // ----------------------------------------------------------------
  // Strobe, select and write decode at the sampling edge
  // ----------------------------------------------------------------
  always_comb begin
    cpu_ok   = !cpu_addr_strobe_n && !select_a_n && !st_ff.asleep;
    ctrl_ok  = !ctrl_addr_strobe_n && !cpu_ok && !st_ff.asleep;
    load     = cpu_ok || ctrl_ok;
    selected = chip_selected(select_a_n, select_b_hi, select_c_n);
    lanes    = lane_mask(all_lanes_write_n, lane_write_enable_n,
                         lane_select_n);
    // Processor-started first cycle ignores the write inputs
    write_now = (lanes != SSP_NO_LANES) && !cpu_ok;
    // Advance counts only inside a burst, never on a load edge
    nxt_step  = (!burst_advance_n && st_ff.active) ?
                2'(st_ff.step + 2'h1) : st_ff.step;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st            = st_ff;
    // Asynchronous sleep and strap pins each pass two flops
    nxt_st.sleep_sync = {st_ff.sleep_sync[0], sleep_request};
    nxt_st.strap_sync = {st_ff.strap_sync[0], burst_order_strap};
    nxt_st.wdata      = dq_in;
    nxt_st.lane_we    = SSP_NO_LANES;
    nxt_st.oe_mask    = 1'b0;
    // Sleep entry and exit after two stable edges
    if (st_ff.sleep_sync[1] != st_ff.asleep) begin
      if (st_ff.sleep_cnt == 2'(SSP_SLEEP_EDGES - 1)) begin
        nxt_st.asleep    = st_ff.sleep_sync[1];
        nxt_st.sleep_cnt = SSP_SLEEP_CNT_RST;
      end else begin
        nxt_st.sleep_cnt = 2'(st_ff.sleep_cnt + 2'h1);
      end
    end else begin
      nxt_st.sleep_cnt = SSP_SLEEP_CNT_RST;
    end
    if (st_ff.asleep) begin
      // A pending access is dropped on entering sleep
      nxt_st.active     = 1'b0;
      nxt_st.read_phase = 1'b0;
    end else if (load) begin
      if (selected) begin
        nxt_st.addr       = addr;
        nxt_st.step       = SSP_STEP_RST;
        nxt_st.active     = 1'b1;
        // Coming out of deselect masks the first read clock
        nxt_st.oe_mask    = !st_ff.active;
        nxt_st.read_phase = !write_now;
        if (write_now) begin
          nxt_st.lane_we = lanes;
        end
      end else begin
        // Deselect ends the burst and floats the pins
        nxt_st.active     = 1'b0;
        nxt_st.read_phase = 1'b0;
      end
    end else if (st_ff.active) begin
      nxt_st.step       = nxt_step;
      nxt_st.read_phase = !write_now;
      if (write_now) begin
        nxt_st.lane_we = lanes;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Reset clears all fields; strap reads linear until resynced
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Core and pin drive
  // ----------------------------------------------------------------
  always_comb begin
    core_addr = {st_ff.addr[ADDR_W-1:SSP_BURST_W], burst_bits};
    core_lane_we = st_ff.lane_we;
    core_wdata   = st_ff.wdata;
    // Flow-through: core read data goes to the pins unregistered
    dq_out       = core_rdata;
    // Output enable acts without the clock
    dq_oe = !out_enable_n && st_ff.read_phase && st_ff.active &&
            !st_ff.oe_mask && !st_ff.asleep;
    sleep_active = st_ff.asleep;
  end

endmodule : ssp_port_ctrl
`default_nettype wire

// ---- bench/ssp_core_model.sv ----
// Memory core model behind the port control
`timescale 1ns/100ps
`default_nettype none
module ssp_core_model
  import ssp_pkg::*;
#(
  parameter int ADDR_W = SSP_ADDR_W
) (
  // Core side of the port control
  input  wire logic                  clk,
  input  wire logic [ADDR_W-1:0]     core_addr,
  input  wire logic [SSP_LANES-1:0]  core_lane_we,
  input  wire logic [SSP_DATA_W-1:0] core_wdata,
  output logic      [SSP_DATA_W-1:0] core_rdata
);
  logic [SSP_DATA_W-1:0] mem [16];
  initial for (int i = 0; i < 16; i++) mem[i] = 32'hc0de_0000 | i;
  assign core_rdata = mem[core_addr[3:0]];
  always @(posedge clk)
    for (int l = 0; l < SSP_LANES; l++)
      if (core_lane_we[l])
        mem[core_addr[3:0]][l*8+:8] <= core_wdata[l*8+:8];
endmodule : ssp_core_model
`default_nettype wire

// ---- bench/ssp_chk_checker.sv ----
// Port assertions for the burst SRAM port control
`timescale 1ns/100ps
`default_nettype none
module ssp_chk
  import ssp_pkg::*;
#(
  parameter int ADDR_W = SSP_ADDR_W
) (
  // Pins
  input wire logic                  clk,
  input wire logic                  sys_rst,
  input wire logic                  cpu_addr_strobe_n,
  input wire logic                  ctrl_addr_strobe_n,
  input wire logic                  burst_advance_n,
  input wire logic                  select_a_n,
  input wire logic                  all_lanes_write_n,
  input wire logic                  lane_write_enable_n,
  input wire logic [SSP_LANES-1:0]  lane_select_n,
  input wire logic                  out_enable_n,
  input wire logic [SSP_DATA_W-1:0] dq_in,
  input wire logic [SSP_DATA_W-1:0] dq_out,
  input wire logic                  dq_oe,
  // Core side and status
  input wire logic [ADDR_W-1:0]     core_addr,
  input wire logic [SSP_LANES-1:0]  core_lane_we,
  input wire logic [SSP_DATA_W-1:0] core_wdata,
  input wire logic [SSP_DATA_W-1:0] core_rdata,
  input wire logic                  sleep_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_oe_gate: assert property (dq_oe |-> !out_enable_n)
    else $error("data pins driven with output enable high");
  chk_flow_data: assert property (dq_oe && cpu_addr_strobe_n &&
    ctrl_addr_strobe_n && burst_advance_n |=> $stable(core_addr) &&
    $stable(dq_out)) else $error("read data moved without a new address");
  chk_wdata_cap: assert property (|core_lane_we |->
    core_wdata == $past(dq_in)) else $error("write data not captured");
  chk_write_float: assert property (|core_lane_we |-> !dq_oe)
    else $error("data pins driven during write");
  chk_all_lanes: assert property (|core_lane_we &&
    !$past(all_lanes_write_n) |-> core_lane_we == SSP_ALL_LANES)
    else $error("global write missed a lane");
  chk_lane_qual: assert property (|core_lane_we &&
    $past(all_lanes_write_n) |-> !$past(lane_write_enable_n) &&
    core_lane_we == ~$past(lane_select_n)) else $error("lane write wrong");
  chk_cpu_ignore: assert property (!cpu_addr_strobe_n &&
    select_a_n && ctrl_addr_strobe_n && burst_advance_n |=>
    $stable(core_addr)) else $error("processor strobe taken when unselected");
  chk_sleep_float: assert property (sleep_active |-> !dq_oe)
    else $error("data pins driven while asleep");
  chk_adv_step: assert property (dq_oe && !burst_advance_n &&
    cpu_addr_strobe_n && ctrl_addr_strobe_n |=>
    core_addr[1:0] != $past(core_addr[1:0])) else $error("burst stalled");
  cover property (|core_lane_we);
  cover property (dq_oe && !burst_advance_n);
  cover property (sleep_active);
endmodule : ssp_chk
bind ssp_port_ctrl ssp_chk #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench for the burst SRAM port control
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import ssp_pkg::*;
  logic        clk = 0, sys_rst = 1, out_enable_n = 0, sleep_request = 0;
  logic        burst_order_strap = 0;
  logic [18:0] addr = 0;
  logic [31:0] dq_in = 0;
  logic [5:0]  ctl = 6'h3a, wr = 6'h3f;
  wire logic   cpu_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n;
  wire logic   select_a_n, select_b_hi, select_c_n;
  wire logic   all_lanes_write_n, lane_write_enable_n, dq_oe, sleep_active;
  wire logic [3:0]  lane_select_n, core_lane_we;
  wire logic [31:0] dq_out, core_wdata, core_rdata;
  wire logic [18:0] core_addr;
  int miscompares = 0, samples_checked = 0, cycles = 0;
  // Rows: {strap, start} beside four expected burst positions
  logic [10:0] rows [8] = '{11'h0e4, 11'h139, 11'h24e, 11'h393,
                            11'h4e4, 11'h5b1, 11'h64e, 11'h71b};
  assign {cpu_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n,
          select_a_n, select_b_hi, select_c_n} = ctl;
  assign {all_lanes_write_n, lane_write_enable_n, lane_select_n} = wr;
  ssp_port_ctrl uut (.*);
  ssp_core_model mdl (.*);
  initial forever #5 clk = ~clk;
  always @(posedge clk) if (++cycles == 3000) begin
    miscompares++;
    tally_and_finish();
  end
  task automatic chk(input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One request for one edge, then idle
  task automatic t(input logic [5:0] c, w, input logic [31:0] d,
                   input logic [18:0] a);
    @(posedge clk);
    ctl <= c;
    wr <= w;
    dq_in <= d;
    addr <= a;
    @(posedge clk);
    ctl <= 6'h3a;
    wr <= 6'h3f;
    #1;
  endtask : t
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    for (int r = 0; r < 8; r++) begin
      if (r > 0) begin
        @(posedge clk);
      end
      sys_rst <= 1;
      burst_order_strap <= rows[r][10];
      repeat (5) @(posedge clk);
      sys_rst <= 0;
      repeat (2) @(posedge clk);
      #1;
      chk({dq_oe, core_lane_we, sleep_active}, 0);
      for (int k = 0; k < 4; k++) begin
        t(k ? 6'h32 : 6'h2a, 6'h3f, 0, {17'h0_0014, rows[r][9:8]});
        chk(core_addr, {17'h0_0014, rows[r][2*k+:2]});
        if (k) chk(dq_oe, 1);
        if (k) chk(dq_out, {30'h3037_8000, rows[r][2*k+:2]});
      end
    end
    t(6'h1a, 6'h1f, 0, 19'h0_0050);
    chk(core_addr, 19'h0_0050);
    t(6'h3a, 6'h2a, 32'h1122_3344, 0);
    chk(core_lane_we, 4'h5);
    chk(core_wdata, 32'h1122_3344);
    chk(dq_oe, 0);
    t(6'h3a, 6'h1f, 32'h5566_7788, 0);
    chk(core_lane_we, 4'hf);
    t(6'h3a, 6'h30, 0, 0);
    chk(core_lane_we, 0);
    t(6'h0a, 6'h1f, 0, 19'h0_0064);
    chk({core_addr, core_lane_we}, {19'h0_0064, 4'h0});
    t(6'h1e, 6'h3f, 0, 19'h0_0070);
    chk(core_addr, 19'h0_0064);
    chk(dq_oe, 1);
    t(6'h28, 6'h3f, 0, 19'h0_0070);
    chk(dq_oe, 0);
    t(6'h2a, 6'h3f, 0, 19'h0_0004);
    chk(dq_oe, 0);
    t(6'h36, 6'h3f, 0, 0);
    chk({dq_oe, core_addr}, {1'b1, 19'h0_0005});
    chk(dq_out, 32'hc0de_0005);
    @(posedge clk);
    out_enable_n <= 1;
    #1;
    chk(dq_oe, 0);
    t(6'h28, 6'h3f, 0, 0);
    @(posedge clk);
    sleep_request <= 1;
    repeat (3) @(posedge clk);
    #1;
    chk(sleep_active, 0);
    @(posedge clk);
    #1;
    chk(sleep_active, 1);
    @(posedge clk);
    sleep_request <= 0;
    repeat (3) @(posedge clk);
    #1;
    chk(sleep_active, 1);
    @(posedge clk);
    #1;
    chk(sleep_active, 0);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
